// *** design/fpk_keypad.sv ***
// Front-panel modulation keypad controller, one module.
// Assumes key strobes arrive over APB writes; environment flags are pins.
//
// Function
// R01: Waveform key lights sine first, then steps triangle, square, rotation, off, wrap.
// R02: Selection starts on ENTER; five seconds without ENTER cancels to static.
// R03: Rate key enters rate entry, lights lamp, shows last rate.
// R04: ENTER commits; hold off drops lamp and shows angle, hold on stays.
// R05: Rate range zero to 1000 Hz, zero at power-up.
// R06: Depth range zero to 180 degrees, zero at power-up.
// R07: Speed signed up to 100000 deg/s, zero at power-up.
// R08: Depth and speed keys enter own modes like rate entry.
// R09: Trim key lights lamp, isolates outputs about twelve seconds, then lamp off.
// R10: Trim refused on overload or zero line-pair voltage.
// R11: Hold key toggles hold; without hold display reverts to shaft angle.
// R12: Local key asks bus release; ignored under lockout; lamp shows result.
// R13: UP adds step size only in angle, speed, rate modes.
// R14: DOWN subtracts step size only in angle, speed, rate modes.
// R15: Knob detents add or subtract step size in same three modes.
// R16: Clear discards pending entry, applied value unchanged.
// R17: Sign key negates value being typed.
// R18: Store key changes nothing.
// R19: Phase within 180 degrees, only in onboard-source reference mode.
// R20: Angle, speed and rate each keep own step size, set via step key.
// R21: Angle entry limited to plus or minus 360 degrees.
// R22: Keys arrive as single strobes with code; timeout from system clock.
module fpk_keypad #(
    parameter int unsigned SEL_TMO = fpk_pkg::SEL_TMO_CYC,
    parameter int unsigned CAL_LEN = fpk_pkg::CAL_CYC
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_overload_flag,
    input  wire logic        i_vll_zero,
    input  wire logic        i_onboard_ref,
    input  wire logic        i_lockout,
    input  wire logic        i_remote,
    output logic [2:0]       o_wave_run,
    output logic [2:0]       o_wave_lamp,
    output logic [2:0]       o_entry_lamp,
    output logic             o_step_lamp,
    output logic             o_hold_lamp,
    output logic             o_trim_lamp,
    output logic             o_outputs_isolated,
    output logic             o_bus_control_lamp,
    output logic             o_bus_release
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]          rst_sync;
        fpk_pkg::fpk_env_t   env_s1;
        fpk_pkg::fpk_env_t   env_s2;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
        fpk_pkg::fpk_wave_t  sel;
        logic                sel_pend;
        fpk_pkg::fpk_wave_t  run;
        logic [31:0]         sel_cnt;
        fpk_pkg::fpk_emode_t emode;
        logic                step_mode;
        logic                hold;
        logic                entry_valid;
        logic signed [31:0]  entry;
        logic signed [31:0]  rate;
        logic signed [31:0]  depth;
        logic signed [31:0]  speed;
        logic signed [31:0]  angle;
        logic signed [31:0]  phase;
        logic signed [31:0]  step_rate;
        logic signed [31:0]  step_speed;
        logic signed [31:0]  step_angle;
        logic                trim;
        logic [31:0]         trim_cnt;
        logic                bus_rel;
        logic signed [31:0]  display;
        logic [2:0]          wave_lamp;
        logic                bus_lamp;
    } fpk_state_t;

    fpk_state_t s_r;
    fpk_state_t s_nxt;
    logic       rst_int_n;
    assign rst_int_n = s_r.rst_sync[1];

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic signed [31:0] clampv(input logic signed [31:0] v,
                                                  input logic signed [31:0] lo,
                                                  input logic signed [31:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clampv

    function automatic logic signed [31:0] cur_val(input fpk_state_t s);
        case (s.emode)
            fpk_pkg::EM_RATE:  return s.rate;
            fpk_pkg::EM_DEPTH: return s.depth;
            fpk_pkg::EM_SPEED: return s.speed;
            fpk_pkg::EM_PHASE: return s.phase;
            default:           return s.angle;
        endcase
    endfunction : cur_val

    function automatic logic signed [31:0] cur_step(input fpk_state_t s);
        case (s.emode)
            fpk_pkg::EM_RATE:  return s.step_rate;
            fpk_pkg::EM_SPEED: return s.step_speed;
            default:           return s.step_angle;
        endcase
    endfunction : cur_step

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic               key_stb;
        fpk_pkg::fpk_key_t  key;
        logic signed [31:0] v;
        logic signed [31:0] d;
        logic               stepping;
        key_stb  = 1'b0;
        key      = fpk_pkg::KEY_NONE;
        v        = 32'sh0;
        d        = 32'sh0;
        stepping = 1'b0;
        s_nxt    = s_r;
        s_nxt.rst_sync = {s_r.rst_sync[0], 1'b1};
        s_nxt.env_s1   = '{i_overload_flag, i_vll_zero, i_onboard_ref, i_lockout, i_remote};
        s_nxt.env_s2   = s_r.env_s1;

        // APB slave, one wait-free access
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (i_psel && !i_penable)
        begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = 32'h0;
            if (i_paddr == fpk_pkg::OFS_STATUS)
            begin
                s_nxt.prdata[fpk_pkg::ST_HOLD]            = s_r.hold;
                s_nxt.prdata[fpk_pkg::ST_CAL]             = s_r.trim;
                s_nxt.prdata[fpk_pkg::ST_BUS]             = s_r.env_s2.remote & ~s_r.bus_rel;
                s_nxt.prdata[fpk_pkg::ST_ISO]             = s_r.trim;
                s_nxt.prdata[fpk_pkg::ST_MODE +: 3]       = s_r.emode;
                s_nxt.prdata[fpk_pkg::ST_SEL +: 3]        = s_r.sel;
                s_nxt.prdata[fpk_pkg::ST_PEND]            = s_r.sel_pend;
            end
            else if (i_paddr == fpk_pkg::OFS_DISPLAY)
                s_nxt.prdata = s_r.display;
            else if (i_paddr == fpk_pkg::OFS_RATE)
                s_nxt.prdata = s_r.rate;
            else if (i_paddr == fpk_pkg::OFS_DEPTH)
                s_nxt.prdata = s_r.depth;
            else if (i_paddr == fpk_pkg::OFS_SPEED)
                s_nxt.prdata = s_r.speed;
            else if (i_paddr == fpk_pkg::OFS_ANGLE)
                s_nxt.prdata = s_r.angle;
            else if (i_paddr == fpk_pkg::OFS_PHASE)
                s_nxt.prdata = s_r.phase;
            else if (i_paddr == fpk_pkg::OFS_WAVE)
                s_nxt.prdata = {29'h0, s_r.run};
            else if (i_paddr == fpk_pkg::OFS_DIGITS)
                s_nxt.prdata = s_r.entry;
            else if (i_paddr != fpk_pkg::OFS_KEY)
                s_nxt.pslverr = 1'b1;
            if (i_pwrite && i_paddr == fpk_pkg::OFS_KEY)
            begin
                key_stb = 1'b1; // R22
                key     = fpk_pkg::fpk_key_t'(i_pwdata[4:0]);
            end
            else if (i_pwrite && i_paddr == fpk_pkg::OFS_DIGITS)
            begin
                s_nxt.entry       = $signed(i_pwdata);
                s_nxt.entry_valid = 1'b1;
            end
            else if (i_pwrite)
                s_nxt.pslverr = 1'b1;
        end

        // Selection timeout
        if (s_r.sel_pend)
        begin
            if (s_r.sel_cnt >= SEL_TMO - 1)
            begin
                s_nxt.sel_pend = 1'b0; // R02
                s_nxt.sel      = fpk_pkg::WV_OFF;
                s_nxt.run      = fpk_pkg::WV_OFF;
            end
            else
                s_nxt.sel_cnt = s_r.sel_cnt + 32'h1; // R22
        end

        // Calibration timer
        if (s_r.trim && s_r.trim_cnt >= CAL_LEN - 1)
            s_nxt.trim = 1'b0; // R09
        else if (s_r.trim)
            s_nxt.trim_cnt = s_r.trim_cnt + 32'h1;

        if (!s_r.env_s2.remote)
            s_nxt.bus_rel = 1'b0;

        if (key_stb)
        begin
            case (key)
                fpk_pkg::KEY_WAVE:
                begin
                    s_nxt.sel_pend = 1'b1; // R01
                    s_nxt.sel_cnt  = 32'h0;
                    if (!s_r.sel_pend || s_r.sel == fpk_pkg::WV_ROT)
                        s_nxt.sel = s_r.sel_pend ? fpk_pkg::WV_OFF : fpk_pkg::WV_SINE;
                    else if (s_r.sel == fpk_pkg::WV_OFF)
                        s_nxt.sel = fpk_pkg::WV_SINE;
                    else
                        s_nxt.sel = fpk_pkg::fpk_wave_t'(s_r.sel + 3'h1);
                end
                fpk_pkg::KEY_RATE, fpk_pkg::KEY_DEPTH, fpk_pkg::KEY_SPEED,
                fpk_pkg::KEY_ANGLE, fpk_pkg::KEY_PHASE:
                begin
                    s_nxt.entry_valid = 1'b0;
                    case (key)
                        fpk_pkg::KEY_RATE:  s_nxt.emode = fpk_pkg::EM_RATE;  // R03
                        fpk_pkg::KEY_DEPTH: s_nxt.emode = fpk_pkg::EM_DEPTH; // R08
                        fpk_pkg::KEY_SPEED: s_nxt.emode = fpk_pkg::EM_SPEED; // R08
                        fpk_pkg::KEY_PHASE: s_nxt.emode = s_r.env_s2.onboard_ref ? fpk_pkg::EM_PHASE
                                                                                  : s_r.emode; // R19
                        default:            s_nxt.emode = fpk_pkg::EM_ANGLE;
                    endcase
                    if (key == fpk_pkg::KEY_PHASE && !s_r.env_s2.onboard_ref)
                        s_nxt.step_mode = s_r.step_mode;
                    else if (s_r.step_mode && key != fpk_pkg::KEY_RATE && key != fpk_pkg::KEY_SPEED
                             && key != fpk_pkg::KEY_ANGLE)
                        s_nxt.step_mode = 1'b0;
                    s_nxt.display = s_nxt.step_mode ? cur_step(s_nxt) : cur_val(s_nxt); // R20
                end
                fpk_pkg::KEY_STEP:
                    s_nxt.step_mode = 1'b1; // R20
                fpk_pkg::KEY_ENTER:
                begin
                    if (s_r.sel_pend)
                    begin
                        s_nxt.run      = s_r.sel; // R02
                        s_nxt.sel_pend = 1'b0;
                    end
                    else if (s_r.emode != fpk_pkg::EM_NONE && s_r.entry_valid)
                    begin
                        v = s_r.entry;
                        if (s_r.step_mode)
                        begin
                            case (s_r.emode)
                                fpk_pkg::EM_RATE:  s_nxt.step_rate  = v; // R20
                                fpk_pkg::EM_SPEED: s_nxt.step_speed = v;
                                default:           s_nxt.step_angle = v;
                            endcase
                        end
                        else
                        begin
                            case (s_r.emode)
                                fpk_pkg::EM_RATE:  s_nxt.rate  = clampv(v, 32'sh0, fpk_pkg::RATE_MAX);  // R05
                                fpk_pkg::EM_DEPTH: s_nxt.depth = clampv(v, 32'sh0, fpk_pkg::DEPTH_MAX); // R06
                                fpk_pkg::EM_SPEED: s_nxt.speed = clampv(v, -fpk_pkg::SPEED_MAX,
                                                                        fpk_pkg::SPEED_MAX);             // R07
                                fpk_pkg::EM_PHASE: s_nxt.phase = clampv(v, -fpk_pkg::PHASE_MAX,
                                                                        fpk_pkg::PHASE_MAX);             // R19
                                default:           s_nxt.angle = clampv(v, -fpk_pkg::ANGLE_MAX,
                                                                        fpk_pkg::ANGLE_MAX);             // R21
                            endcase
                        end
                        s_nxt.entry_valid = 1'b0;
                        s_nxt.display     = s_nxt.step_mode ? cur_step(s_nxt) : cur_val(s_nxt);
                        if (!s_r.hold)
                        begin
                            s_nxt.emode     = fpk_pkg::EM_NONE; // R04
                            s_nxt.step_mode = 1'b0;
                            s_nxt.display   = s_nxt.angle;     // R11
                        end
                    end
                end
                fpk_pkg::KEY_UP, fpk_pkg::KEY_DOWN, fpk_pkg::KEY_CW, fpk_pkg::KEY_CCW:
                begin
                    stepping = !s_r.step_mode && (s_r.emode == fpk_pkg::EM_RATE
                               || s_r.emode == fpk_pkg::EM_SPEED || s_r.emode == fpk_pkg::EM_ANGLE);
                    d = (key == fpk_pkg::KEY_UP || key == fpk_pkg::KEY_CW) ? cur_step(s_r)
                                                                            : -cur_step(s_r);
                    if (stepping)
                    begin
                        v = cur_val(s_r) + d; // R13 R14 R15
                        case (s_r.emode)
                            fpk_pkg::EM_RATE:  s_nxt.rate  = clampv(v, 32'sh0, fpk_pkg::RATE_MAX);
                            fpk_pkg::EM_SPEED: s_nxt.speed = clampv(v, -fpk_pkg::SPEED_MAX, fpk_pkg::SPEED_MAX);
                            default:           s_nxt.angle = clampv(v, -fpk_pkg::ANGLE_MAX, fpk_pkg::ANGLE_MAX);
                        endcase
                        s_nxt.display = cur_val(s_nxt);
                    end
                end
                fpk_pkg::KEY_CLEAR:
                begin
                    s_nxt.entry_valid = 1'b0; // R16
                    s_nxt.entry       = 32'sh0;
                end
                fpk_pkg::KEY_SIGN:
                    s_nxt.entry = -s_r.entry; // R17
                fpk_pkg::KEY_TRIM:
                    if (!s_r.trim && !s_r.env_s2.overload && !s_r.env_s2.vll_zero) // R10
                    begin
                        s_nxt.trim     = 1'b1; // R09
                        s_nxt.trim_cnt = 32'h0;
                    end
                fpk_pkg::KEY_HOLD:
                    s_nxt.hold = ~s_r.hold; // R11
                fpk_pkg::KEY_LOCAL:
                    if (s_r.env_s2.remote && !s_r.env_s2.lockout)
                        s_nxt.bus_rel = 1'b1; // R12
                default:
                    s_nxt.display = s_r.display; // R18
            endcase
        end

        if (!s_r.env_s2.onboard_ref)
            s_nxt.phase = fpk_pkg::PARAM_RST; // R19
        s_nxt.wave_lamp = s_nxt.sel_pend ? s_nxt.sel : s_nxt.run;
        s_nxt.bus_lamp  = s_nxt.env_s2.remote & ~s_nxt.bus_rel; // R12
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s_r <= '0;
            s_r.step_rate  <= fpk_pkg::STEP_RST;
            s_r.step_speed <= fpk_pkg::STEP_RST;
            s_r.step_angle <= fpk_pkg::STEP_RST;
        end
        else if (!rst_int_n)
        begin
            s_r.rst_sync <= s_nxt.rst_sync;
            s_r.env_s1   <= s_nxt.env_s1;
            s_r.env_s2   <= s_nxt.env_s2;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_prdata           = s_r.prdata;
    assign o_pready           = s_r.pready;
    assign o_pslverr          = s_r.pslverr;
    assign o_wave_run         = s_r.run;
    assign o_wave_lamp        = s_r.wave_lamp;
    assign o_entry_lamp       = s_r.emode;
    assign o_step_lamp        = s_r.step_mode;
    assign o_hold_lamp        = s_r.hold;
    assign o_trim_lamp        = s_r.trim;
    assign o_outputs_isolated = s_r.trim;
    assign o_bus_control_lamp = s_r.bus_lamp;
    assign o_bus_release      = s_r.bus_rel;

endmodule : fpk_keypad

// *** design/fpk_pkg.sv ***
// Package for the front-panel modulation keypad controller.
// Assumes a 40 MHz system clock and APB register access.
package fpk_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 40000000;
    localparam int unsigned SEL_TMO_S     = 5;
    localparam int unsigned CAL_TIME_S    = 12;
    localparam int unsigned SEL_TMO_CYC   = SEL_TMO_S * CLK_HZ;
    localparam int unsigned CAL_CYC       = CAL_TIME_S * CLK_HZ;

    // ------------------------------------------------------------
    // Limits and defaults (value units: rate Hz, depth deg, speed deg/s, angle deg)
    // ------------------------------------------------------------
    localparam logic signed [31:0] RATE_MAX    = 32'sd1000;
    localparam logic signed [31:0] DEPTH_MAX   = 32'sd180;
    localparam logic signed [31:0] SPEED_MAX   = 32'sd100000;
    localparam logic signed [31:0] ANGLE_MAX   = 32'sd360;
    localparam logic signed [31:0] PHASE_MAX   = 32'sd180;
    localparam logic signed [31:0] PARAM_RST   = 32'sd0;
    localparam logic signed [31:0] STEP_RST    = 32'sd1;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_KEY      = 8'h00;
    localparam logic [7:0] OFS_DIGITS   = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_DISPLAY  = 8'h0c;
    localparam logic [7:0] OFS_RATE     = 8'h10;
    localparam logic [7:0] OFS_DEPTH    = 8'h14;
    localparam logic [7:0] OFS_SPEED    = 8'h18;
    localparam logic [7:0] OFS_ANGLE    = 8'h1c;
    localparam logic [7:0] OFS_PHASE    = 8'h20;
    localparam logic [7:0] OFS_WAVE     = 8'h24;

    // Status field positions
    localparam int unsigned ST_HOLD  = 0;
    localparam int unsigned ST_CAL   = 1;
    localparam int unsigned ST_BUS   = 2;
    localparam int unsigned ST_ISO   = 3;
    localparam int unsigned ST_MODE  = 4;
    localparam int unsigned ST_SEL   = 8;
    localparam int unsigned ST_PEND  = 11;

    // ------------------------------------------------------------
    // Key codes
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        KEY_NONE, KEY_WAVE, KEY_ENTER, KEY_RATE, KEY_DEPTH, KEY_SPEED,
        KEY_ANGLE, KEY_STEP, KEY_TRIM, KEY_HOLD, KEY_LOCAL, KEY_UP,
        KEY_DOWN, KEY_CW, KEY_CCW, KEY_CLEAR, KEY_SIGN, KEY_STORE,
        KEY_PHASE, KEY_DIGIT
    } fpk_key_t;

    typedef enum logic [2:0] {
        WV_OFF, WV_SINE, WV_TRI, WV_SQUARE, WV_ROT
    } fpk_wave_t;

    typedef enum logic [2:0] {
        EM_NONE, EM_RATE, EM_DEPTH, EM_SPEED, EM_ANGLE, EM_PHASE
    } fpk_emode_t;

    typedef struct packed {
        logic             strobe;
        fpk_key_t         code;
        logic signed [31:0] digits;
    } fpk_key_evt_t;

    typedef struct packed {
        logic       overload;
        logic       vll_zero;
        logic       onboard_ref;
        logic       lockout;
        logic       remote;
    } fpk_env_t;

endpackage : fpk_pkg

// *** verification/fpk_keypad_sva.sv ***
// Port checker for the keypad controller.
// Assumes the bench keeps APB setup and access order.
module fpk_keypad_chk #(
    parameter int unsigned SEL_TMO = 40,
    parameter int unsigned CAL_LEN = 40
) (
    input wire logic        i_clk_sys, i_rst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic        i_overload_flag, i_vll_zero, i_lockout, o_hold_lamp, o_trim_lamp,
    input wire logic        o_outputs_isolated, o_bus_control_lamp, o_bus_release,
    input wire logic [2:0]  o_wave_run, o_wave_lamp, o_entry_lamp
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    logic [31:0] idle_r;
    logic [31:0] cal_r;
    wire keyw = i_psel && !i_penable && i_pwrite && i_paddr == fpk_pkg::OFS_KEY;
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        idle_r <= !i_rst_n || keyw ? '0 : idle_r + 32'(idle_r != '1);
        cal_r  <= !i_rst_n || !o_trim_lamp ? '0 : cal_r + 1;
    end
    chk_ready_next: assert property (i_psel && !i_penable |=> o_pready) else $error("no ready");
    chk_ready_pulse: assert property (o_pready |=> !o_pready) else $error("ready too long");
    chk_err_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
    chk_trim_cause: assert property ($rose(o_trim_lamp) |-> $past(keyw && i_pwdata[4:0] == 5'h08)
        && !$past(i_overload_flag, 3) && !$past(i_vll_zero, 3)) else $error("bad trim start");
    chk_trim_iso: assert property (o_trim_lamp |-> o_outputs_isolated) else $error("not isolated");
    chk_cal_len: assert property ($fell(o_trim_lamp) |-> cal_r + 2 >= CAL_LEN && cal_r <= CAL_LEN + 2)
        else $error("bad trim length");
    chk_sel_tmo: assert property (idle_r > SEL_TMO + 4 |-> o_wave_lamp == o_wave_run)
        else $error("selection kept");
    chk_hold_toggle: assert property (keyw && i_pwdata[4:0] == 5'h09 |=> o_hold_lamp != $past(o_hold_lamp))
        else $error("hold not toggled");
    chk_store_none: assert property (keyw && i_pwdata[4:0] == 5'h11 |=> $stable(o_entry_lamp)
        && $stable(o_hold_lamp) && $stable(o_wave_lamp)) else $error("store acted");
    chk_bus_lamp: assert property (o_bus_control_lamp |-> !o_bus_release) else $error("lamp on released");
    chk_release_cause: assert property ($rose(o_bus_release) |-> $past(keyw && i_pwdata[4:0] == 5'h0a)
        && !$past(i_lockout, 3)) else $error("bad release");
endmodule : fpk_keypad_chk

bind fpk_keypad fpk_keypad_chk #(.SEL_TMO(SEL_TMO), .CAL_LEN(CAL_LEN)) chk_inst (.i_clk_sys, .i_rst_n, .i_psel,
    .i_penable, .i_pwrite, .o_pready, .o_pslverr, .i_paddr, .i_pwdata, .i_overload_flag, .i_vll_zero, .i_lockout,
    .o_hold_lamp, .o_trim_lamp, .o_outputs_isolated, .o_bus_control_lamp, .o_bus_release, .o_wave_run,
    .o_wave_lamp, .o_entry_lamp);

// *** verification/fpk_operator.sv ***
// Operator model: panel flag levels, changed just after a clock edge.
// Assumes one system clock.
module fpk_operator (
    input  wire logic              i_clk_sys,
    input  wire fpk_pkg::fpk_env_t i_want,
    output fpk_pkg::fpk_env_t      o_env = '0
);
    timeunit 1ns;
    timeprecision 100ps;
    always_ff @(posedge i_clk_sys) o_env <= i_want;
endmodule : fpk_operator

// *** verification/testbench.sv ***
// Self-checking bench for the keypad controller.
// Assumes the APB slave answers after one access cycle.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pw = 0, perr, er, rdy, stl, hl, tl, iso, bl, rel;
    logic [7:0]  pa = '0;
    logic [31:0] pwd = '0, prd, rd;
    logic [2:0]  run, wl, el;
    fpk_pkg::fpk_env_t want = '0, env;
    int err_total = 0, tests_run = 0;
    always #12.5 clk = ~clk;
    fpk_operator fpk_operator_inst (.i_clk_sys(clk), .i_want(want), .o_env(env));
    fpk_keypad #(.SEL_TMO(40), .CAL_LEN(40)) fpk_keypad_inst (.i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pw), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy),
        .o_pslverr(perr), .i_overload_flag(env.overload), .i_vll_zero(env.vll_zero),
        .i_onboard_ref(env.onboard_ref), .i_lockout(env.lockout), .i_remote(env.remote), .o_wave_run(run),
        .o_wave_lamp(wl), .o_entry_lamp(el), .o_step_lamp(stl), .o_hold_lamp(hl), .o_trim_lamp(tl),
        .o_outputs_isolated(iso), .o_bus_control_lamp(bl), .o_bus_release(rel));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pw <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic key(input fpk_pkg::fpk_key_t k);
        apb(1'b1, fpk_pkg::OFS_KEY, {27'h0, k});
    endtask : key
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdc
    task automatic setenv(input fpk_pkg::fpk_env_t e);
        want <= e;
        repeat (5) @(posedge clk);
    endtask : setenv
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim
    initial
    begin
        #(25 * 3000);
        err_total++;
        end_sim;
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rdc(fpk_pkg::OFS_RATE, 32'h0);
        rdc(fpk_pkg::OFS_DEPTH, 32'h0);
        rdc(fpk_pkg::OFS_SPEED, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk(er, 1'b1);
        key(fpk_pkg::KEY_RATE);
        chk(el, 3'h1);
        apb(1'b1, fpk_pkg::OFS_DIGITS, 32'h7d0);
        key(fpk_pkg::KEY_ENTER);
        chk(el, 3'h0);
        rdc(fpk_pkg::OFS_RATE, 32'h3e8);
        key(fpk_pkg::KEY_SPEED);
        chk(el, 3'h3);
        apb(1'b1, fpk_pkg::OFS_DIGITS, 32'h12c);
        key(fpk_pkg::KEY_SIGN);
        key(fpk_pkg::KEY_ENTER);
        rdc(fpk_pkg::OFS_SPEED, 32'hfffffed4);
        key(fpk_pkg::KEY_SPEED);
        key(fpk_pkg::KEY_UP);
        key(fpk_pkg::KEY_UP);
        key(fpk_pkg::KEY_DOWN);
        rdc(fpk_pkg::OFS_SPEED, 32'hfffffed5);
        key(fpk_pkg::KEY_CW);
        key(fpk_pkg::KEY_CW);
        key(fpk_pkg::KEY_CCW);
        rdc(fpk_pkg::OFS_SPEED, 32'hfffffed6);
        key(fpk_pkg::KEY_DEPTH);
        chk(el, 3'h2);
        apb(1'b1, fpk_pkg::OFS_DIGITS, 32'h32);
        key(fpk_pkg::KEY_CLEAR);
        key(fpk_pkg::KEY_UP);
        key(fpk_pkg::KEY_ENTER);
        rdc(fpk_pkg::OFS_DEPTH, 32'h0);
        $display("Test entry done");
        key(fpk_pkg::KEY_HOLD);
        chk(hl, 1'b1);
        key(fpk_pkg::KEY_RATE);
        apb(1'b1, fpk_pkg::OFS_DIGITS, 32'h7);
        key(fpk_pkg::KEY_ENTER);
        chk(el, 3'h1);
        rdc(fpk_pkg::OFS_RATE, 32'h7);
        key(fpk_pkg::KEY_STORE);
        key(fpk_pkg::KEY_HOLD);
        chk(hl, 1'b0);
        $display("Test hold done");
        for (int i = 1; i <= 6; i++)
        begin
            key(fpk_pkg::KEY_WAVE);
            chk(wl, 32'(i % 5));
        end
        chk(run, 3'h0);
        key(fpk_pkg::KEY_ENTER);
        chk(run, 3'h1);
        key(fpk_pkg::KEY_WAVE);
        repeat (60) @(posedge clk);
        chk(run, 3'h0);
        $display("Test wave done");
        setenv(5'h10);
        key(fpk_pkg::KEY_TRIM);
        chk(tl, 1'b0);
        setenv(5'h08);
        key(fpk_pkg::KEY_TRIM);
        chk(tl, 1'b0);
        setenv(5'h00);
        key(fpk_pkg::KEY_TRIM);
        chk(iso, 1'b1);
        repeat (50) @(posedge clk);
        chk(tl, 1'b0);
        setenv(5'h03);
        key(fpk_pkg::KEY_LOCAL);
        chk(bl, 1'b1);
        setenv(5'h01);
        key(fpk_pkg::KEY_LOCAL);
        chk(rel, 1'b1);
        key(fpk_pkg::KEY_STEP);
        key(fpk_pkg::KEY_ANGLE);
        chk(stl, 1'b1);
        apb(1'b1, fpk_pkg::OFS_DIGITS, 32'h2d);
        key(fpk_pkg::KEY_ENTER);
        key(fpk_pkg::KEY_ANGLE);
        key(fpk_pkg::KEY_UP);
        rdc(fpk_pkg::OFS_ANGLE, 32'h2d);
        $display("Test trim, local and step done");
        end_sim;
    end
endmodule : testbench
